// >>> design/brmc_pkg.sv
package brmc_pkg;
   // operating mode field encoding (3 bits)
   localparam logic [2:0] MODE_OFF = 3'h4;
   localparam logic [2:0] MODE_PFM = 3'h5;
   localparam logic [2:0] MODE_APS = 3'h6;
   localparam logic [2:0] MODE_PWM = 3'h7;
   localparam logic [2:0] MODE_RESET = 3'h4;
   // voltage code
   localparam int CODE_W = 7;
   localparam logic [6:0] CODE_RESET = 7'h7F;
   localparam logic [6:0] CODE_ZERO = 7'h00;
   // code bus target select values
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_CORE = 2'h1;
   localparam logic [1:0] SEL_GFX = 2'h2;
   // reference range and step, in microvolts
   localparam int VMIN_UV = 300000;
   localparam int VMAX_UV = 1200000;
   localparam int STEP_UV = 12500;
   // slew: 25 mV per microsecond, one 12.5 mV step per half microsecond
   localparam int SLEW_MV_PER_US = 25;
   localparam int CLK_MHZ = 100;
   localparam int STEP_TIME_NS = (STEP_UV * 1000) / (SLEW_MV_PER_US * 1000);
   localparam int STEP_CYCLES = (STEP_TIME_NS * CLK_MHZ) / 1000;
   localparam logic [15:0] STEP_CNT_MAX = 16'(STEP_CYCLES - 1);
   // test unlock key sequence, arbitrary values
   localparam logic [7:0] KEY_A = 8'hA5;
   localparam logic [7:0] KEY_B = 8'h5A;
   // adc sample width
   localparam int ADC_W = 10;
   typedef enum logic [1:0] {TK_IDLE, TK_ONE, TK_OPEN} brmc_tkey_t;
endpackage

// >>> design/brmc_slew.sv
`timescale 1ns/100ps
// reference ramp: walks one code step per slew interval toward target
module brmc_slew (
   input wire logic clk_in,                 // system clock
   input wire logic rst_n_in,               // async reset, active low
   input wire logic [6:0] target_in,        // requested code
   input wire logic zero_in,                // drive ramp toward zero code
   output logic [6:0] ref_out,              // present reference code
   output logic settled_out                 // reference equals target, or zero code while zero_in
);
   logic [15:0] cnt_r;
   logic [6:0] ref_r;
   logic [6:0] goal;

   assign goal = zero_in ? brmc_pkg::CODE_ZERO : target_in;

   // -----------------------------------------------------------------
   // step timer: one enable per step interval
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 16'h0000;
      end else if (ref_r == goal || cnt_r == brmc_pkg::STEP_CNT_MAX) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   // one step per interval keeps the ramp at the fixed slew [R10]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_r <= brmc_pkg::CODE_ZERO;
      end else if (cnt_r == brmc_pkg::STEP_CNT_MAX) begin
         if (ref_r < goal) begin
            ref_r <= ref_r + 7'h01;
         end else if (ref_r > goal) begin
            ref_r <= ref_r - 7'h01;
         end
      end
   end

   assign ref_out = ref_r;
   assign settled_out = (ref_r == goal);

   // ref never moves by more than one code per step interval
   chk_slew_one_step: assert property (@(posedge clk_in) disable iff // [R10]
      (!rst_n_in) ref_r != $past(ref_r) |-> (ref_r == $past(ref_r) + 7'h01
      || ref_r == $past(ref_r) - 7'h01))
      else $error("reference jumped more than one step");
   chk_slew_no_early: assert property (@(posedge clk_in) disable iff // [R10]
      (!rst_n_in) cnt_r != brmc_pkg::STEP_CNT_MAX |=> $stable(ref_r))
      else $error("reference moved before step interval");
endmodule

// >>> design/brmc_top.sv
`timescale 1ns/100ps
//
// Overview of operation
// (R1) mode off stops switching and discharges the output.
// (R2) pfm mode keeps regulator on, always pulse frequency modulation.
// (R3) auto skip keeps regulator on, load picks skipping or full pwm.
// (R4) pwm mode keeps regulator on in full pwm regardless of load.
// (R5) test/trim entry only after a deliberate two-key unlock sequence.
// (R6) 7-bit code from pins sets the regulator target.
// (R7) target spans 0.3 to 1.2 V in 12.5 mV code steps.
// (R8) code sampled continuously into hidden holding registers.
// (R9) core rail accepts code only while its select grants the bus.
// (R10) reference ramps to new target at 25 mV per microsecond.
// (R11) controller selects pfm, auto skip or pwm switching mode.
// (R12) any shutdown of the regulator discharges the output.
// (R13) sensed load current converted and held in a readable register.
// (R14) over-current limits cycle by cycle and raises the rail fault.
// (R15) rail fault asserts the shared regulator fault interrupt.
// (R16) shared 7-bit code bus, two selects pick core or graphics.
// (R17) cpu loads graphics code by driving selects to 10.
// (R18) cpu passes through 00 between 10 and 01.
// (R19) override bit picks pin code or controller-written code field.
// (R20) mode field: 4 off, 5 pfm, 6 auto skip, 7 pwm; 0-3 reserved.
// (R21) fault interrupt stays asserted until software acknowledges it.
//
module brmc_top (
   input wire logic clk_in,                  // 100 MHz clock
   input wire logic rst_n_in,                // async reset, active low
   input wire logic [6:0] voltage_code_in,   // shared code bus pins
   input wire logic [1:0] code_target_select_in, // bus select pins
   input wire logic [2:0] core_mode_field_in,  // mode from controller
   input wire logic [6:0] core_code_field_in,  // code from controller
   input wire logic core_code_override_in,   // 1: use controller code
   input wire logic [7:0] test_key_in,       // test unlock key value
   input wire logic test_key_wr_in,          // key write strobe
   input wire logic over_current_in,         // comparator, async pin
   input wire logic load_ok_in,              // light load, async pin
   input wire logic [9:0] adc_data_in,       // current-sense adc word
   input wire logic adc_valid_in,            // adc word valid strobe
   input wire logic fault_ack_in,            // software fault clear
   output logic switch_en_out,               // gate drive enable
   output logic pfm_sel_out,                 // run pulse frequency mode
   output logic skip_sel_out,                // pulse skipping active
   output logic discharge_out,               // output discharge switch
   output logic current_limit_out,           // cycle limit active
   output logic test_mode_out,               // test/trim mode active
   output logic [6:0] ref_code_out,          // reference dac code
   output logic [6:0] target_code_out,       // latched target code
   output logic ref_settled_out,             // ramp reached target (zero code in off mode)
   output logic [9:0] load_current_out,      // held current reading
   output logic core_rail_fault_out,         // rail fault level
   output logic regulator_fault_irq_out      // sticky fault interrupt
);
   logic [6:0] vc_s1_r;
   logic [6:0] vc_s2_r;
   logic [1:0] sel_s1_r;
   logic [1:0] sel_s2_r;
   logic [1:0] oc_s_r;
   logic [1:0] ld_s_r;
   logic [6:0] pin_hold_r;
   logic [6:0] target_r;
   logic [2:0] mode_r;
   brmc_pkg::brmc_tkey_t tkey_r;
   logic test_r;
   logic [9:0] cur_r;
   logic fault_r;
   logic irq_r;
   logic sw_r, pfm_r, skip_r, dis_r, lim_r;
   logic [6:0] ref_code;
   logic settled;
   logic settled_r;
   logic mode_off;
   logic valid_mode;

   function automatic logic mode_is_legal(input logic [2:0] m);
      mode_is_legal = (m == brmc_pkg::MODE_OFF) ||
         (m == brmc_pkg::MODE_PFM) || (m == brmc_pkg::MODE_APS) ||
         (m == brmc_pkg::MODE_PWM);
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   // two flops per pin; bus skew may still give one bad sample, which
   // the continuous resampling overwrites next cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vc_s1_r <= brmc_pkg::CODE_ZERO;
         vc_s2_r <= brmc_pkg::CODE_ZERO;
         sel_s1_r <= brmc_pkg::SEL_NONE;
         sel_s2_r <= brmc_pkg::SEL_NONE;
         oc_s_r <= 2'h0;
         ld_s_r <= 2'h0;
      end else begin
         vc_s1_r <= voltage_code_in;
         vc_s2_r <= vc_s1_r;
         sel_s1_r <= code_target_select_in;
         sel_s2_r <= sel_s1_r;
         oc_s_r <= {oc_s_r[0], over_current_in};
         ld_s_r <= {ld_s_r[0], load_ok_in};
      end
   end

   // -----------------------------------------------------------------
   // code capture
   // -----------------------------------------------------------------
   // hidden holding register, loaded every cycle the core select
   // grants the bus; graphics select (10) leaves it alone
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_hold_r <= brmc_pkg::CODE_RESET;
      end else if (sel_s2_r == brmc_pkg::SEL_CORE) begin // [R9] [R16]
         pin_hold_r <= vc_s2_r; // [R8] [R6]
      end
   end

   // target follows pins or the controller field; one code step is one
   // 12.5 mV dac step inside the 0.3 to 1.2 V span [R7]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         target_r <= brmc_pkg::CODE_RESET;
      end else if (core_code_override_in) begin // [R19]
         target_r <= core_code_field_in;
      end else begin
         target_r <= pin_hold_r; // [R6]
      end
   end

   // -----------------------------------------------------------------
   // mode register
   // -----------------------------------------------------------------
   // reserved codes are ignored so a stray write cannot kill the rail
   assign valid_mode = mode_is_legal(core_mode_field_in);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_r <= brmc_pkg::MODE_RESET;
      end else if (valid_mode) begin // [R20] [R11]
         mode_r <= core_mode_field_in;
      end
   end
   assign mode_off = (mode_r == brmc_pkg::MODE_OFF);

   // -----------------------------------------------------------------
   // test/trim unlock
   // -----------------------------------------------------------------
   // two matching keys in a row open it; any further key write closes it
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tkey_r <= brmc_pkg::TK_IDLE;
      end else if (test_key_wr_in) begin
         unique case (tkey_r)
            brmc_pkg::TK_IDLE: begin
               tkey_r <= (test_key_in == brmc_pkg::KEY_A) ?
                  brmc_pkg::TK_ONE : brmc_pkg::TK_IDLE; // [R5]
            end
            brmc_pkg::TK_ONE: begin
               tkey_r <= (test_key_in == brmc_pkg::KEY_B) ?
                  brmc_pkg::TK_OPEN : brmc_pkg::TK_IDLE; // [R5]
            end
            brmc_pkg::TK_OPEN: begin
               tkey_r <= brmc_pkg::TK_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         test_r <= 1'b0;
      end else begin
         test_r <= (tkey_r == brmc_pkg::TK_OPEN); // [R5]
      end
   end

   // -----------------------------------------------------------------
   // reference ramp
   // -----------------------------------------------------------------
   brmc_slew u_slew (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .target_in(target_r),
      .zero_in(mode_off),
      .ref_out(ref_code),
      .settled_out(settled)
   );

   // settle flag re-timed so the pin comes from a flop; it lags the
   // compare by one cycle, which a poller only sees as a short delay
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         settled_r <= 1'b1;
      end else begin
         settled_r <= settled; // [R10]
      end
   end

   // -----------------------------------------------------------------
   // switching control
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sw_r <= 1'b0;
         pfm_r <= 1'b0;
         skip_r <= 1'b0;
         dis_r <= 1'b1;
      end else begin
         sw_r <= !mode_off; // [R1]
         dis_r <= mode_off; // [R1] [R12]
         pfm_r <= (mode_r == brmc_pkg::MODE_PFM); // [R2]
         // auto mode skips only while load is light [R3]; pwm never [R4]
         skip_r <= (mode_r == brmc_pkg::MODE_APS) && ld_s_r[1];
      end
   end

   // -----------------------------------------------------------------
   // current reading and fault
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur_r <= 10'h000;
      end else if (adc_valid_in) begin
         cur_r <= adc_data_in; // [R13]
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lim_r <= 1'b0;
         fault_r <= 1'b0;
      end else begin
         lim_r <= oc_s_r[1] && !mode_off; // [R14]
         fault_r <= oc_s_r[1] && !mode_off; // [R14]
      end
   end
   // sticky irq: a new fault wins over a same-cycle ack
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_r <= 1'b0;
      end else if (fault_r) begin
         irq_r <= 1'b1; // [R15]
      end else if (fault_ack_in) begin
         irq_r <= 1'b0; // [R21]
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign switch_en_out = sw_r;
   assign pfm_sel_out = pfm_r;
   assign skip_sel_out = skip_r;
   assign discharge_out = dis_r;
   assign current_limit_out = lim_r;
   assign test_mode_out = test_r;
   assign ref_code_out = ref_code;
   assign target_code_out = target_r;
   assign ref_settled_out = settled_r;
   assign load_current_out = cur_r;
   assign core_rail_fault_out = fault_r;
   assign regulator_fault_irq_out = irq_r;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence s_off_seen;
      mode_r == brmc_pkg::MODE_OFF;
   endsequence
   sequence s_off_out;
      !sw_r && dis_r;
   endsequence
   chk_off_discharge: assert property (@(posedge clk_in) disable iff // [R1]
      (!rst_n_in) s_off_seen |=> s_off_out)
      else $error("off mode still switching or not discharging");
   chk_pfm_only: assert property (@(posedge clk_in) disable iff // [R2]
      (!rst_n_in) mode_r == brmc_pkg::MODE_PFM |=> pfm_r && sw_r && !skip_r)
      else $error("pfm mode output wrong");
   chk_aps_follow: assert property (@(posedge clk_in) disable iff // [R3]
      (!rst_n_in) mode_r == brmc_pkg::MODE_APS |=> skip_r == $past(ld_s_r[1]))
      else $error("auto skip does not follow load");
   chk_pwm_full: assert property (@(posedge clk_in) disable iff // [R4]
      (!rst_n_in) mode_r == brmc_pkg::MODE_PWM |=> sw_r && !pfm_r && !skip_r)
      else $error("pwm mode not in full pwm");
   chk_test_key: assert property (@(posedge clk_in) disable iff // [R5]
      (!rst_n_in) $rose(test_r) |-> $past(tkey_r == brmc_pkg::TK_OPEN))
      else $error("test mode entered without unlock");
   chk_core_capture: assert property (@(posedge clk_in) disable iff // [R9]
      (!rst_n_in) sel_s2_r == brmc_pkg::SEL_CORE && !core_code_override_in
      ##1 !core_code_override_in |=> target_r == $past(vc_s2_r, 2))
      else $error("core code not captured from bus");
   chk_gfx_ignored: assert property (@(posedge clk_in) disable iff // [R16]
      (!rst_n_in) sel_s2_r != brmc_pkg::SEL_CORE |=> $stable(pin_hold_r))
      else $error("hold changed without core select");
   chk_override: assert property (@(posedge clk_in) disable iff // [R19]
      (!rst_n_in) core_code_override_in |=>
      target_r == $past(core_code_field_in))
      else $error("override field not applied");
   chk_mode_legal: assert property (@(posedge clk_in) disable iff // [R20]
      (!rst_n_in) !mode_is_legal(core_mode_field_in) |=> $stable(mode_r))
      else $error("reserved mode code accepted");
   chk_fault_irq: assert property (@(posedge clk_in) disable iff // [R15]
      (!rst_n_in) fault_r |=> irq_r)
      else $error("fault did not raise interrupt");
   chk_irq_hold: assert property (@(posedge clk_in) disable iff // [R21]
      (!rst_n_in) irq_r && !fault_ack_in |=> irq_r)
      else $error("interrupt dropped without ack");
   chk_oc_fault: assert property (@(posedge clk_in) disable iff // [R14]
      (!rst_n_in) oc_s_r[1] && !mode_off |=> fault_r && lim_r)
      else $error("over-current not flagged");
endmodule

// >>> tb/brmc_cpu_model.sv
`timescale 1ns/100ps
// --------------------------------------------------------------------
// far-side processor driving the shared code bus and rail selects
// --------------------------------------------------------------------
module brmc_cpu_model (
   input wire logic clk_in,                   // bench clock
   input wire logic load_req_in,              // start one code load
   input wire logic load_gfx_in,              // 1: graphics rail target
   input wire logic [6:0] load_code_in,       // code to place on bus
   output logic [6:0] voltage_code_out,       // shared code bus
   output logic [1:0] code_target_select_out, // rail select lines
   output logic busy_out                      // load in progress
);
   int phase = 0;
   logic [6:0] last_code = 7'h00;

   initial begin
      voltage_code_out = 7'h55;
      code_target_select_out = brmc_pkg::SEL_NONE;
      busy_out = 1'b0;
   end

   // select only ever leaves 00 for one rail, so 10 never meets 01
   always @(posedge clk_in) begin
      if (phase == 0) begin
         voltage_code_out <= ~voltage_code_out; // unowned bus churns
         if (load_req_in) begin
            busy_out <= 1'b1;
            phase <= 1;
         end
      end else if (phase == 1) begin
         voltage_code_out <= load_code_in;
         last_code <= load_code_in;
         code_target_select_out <= load_gfx_in ? brmc_pkg::SEL_GFX :
            brmc_pkg::SEL_CORE;
         phase <= 2;
      end else if (phase < 10) begin
         phase <= phase + 1; // hold bus long enough for the synchronisers
      end else begin
         code_target_select_out <= brmc_pkg::SEL_NONE;
         voltage_code_out <= ~last_code; // released bus shows no stale code
         busy_out <= 1'b0;
         phase <= 0;
      end
   end
endmodule

// >>> tb/brmc_tb_top.sv
`timescale 1ns/100ps
module brmc_tb_top;
   logic clk_in, rst_n_in, core_code_override_in, test_key_wr_in;
   logic over_current_in, load_ok_in, adc_valid_in, fault_ack_in;
   logic load_req, load_gfx, cpu_busy, switch_en, pfm_sel, skip_sel;
   logic discharge, cur_lim, test_mode, settled, core_fault, fault_irq;
   logic [2:0] core_mode_field_in, m;
   logic [6:0] core_code_field_in, load_code, voltage_code, ref_code;
   logic [6:0] target_code, c;
   logic [1:0] code_sel;
   logic [7:0] test_key_in;
   logic [9:0] adc_data_in, load_current, d;
   logic [2:0] modes [4] = '{3'h5, 3'h6, 3'h7, 3'h4};
   logic [6:0] codes [4] = '{7'h7F, 7'h11, 7'h00, 7'h09};
   logic [31:0] seed = 32'h46;
   int mismatches = 0;
   int n_compared = 0;

   brmc_cpu_model cpu_u (.clk_in(clk_in), .load_req_in(load_req),
      .load_gfx_in(load_gfx), .load_code_in(load_code),
      .voltage_code_out(voltage_code), .code_target_select_out(code_sel),
      .busy_out(cpu_busy));

   brmc_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .voltage_code_in(voltage_code), .code_target_select_in(code_sel),
      .core_mode_field_in(core_mode_field_in),
      .core_code_field_in(core_code_field_in),
      .core_code_override_in(core_code_override_in),
      .test_key_in(test_key_in), .test_key_wr_in(test_key_wr_in),
      .over_current_in(over_current_in), .load_ok_in(load_ok_in),
      .adc_data_in(adc_data_in), .adc_valid_in(adc_valid_in),
      .fault_ack_in(fault_ack_in), .switch_en_out(switch_en),
      .pfm_sel_out(pfm_sel), .skip_sel_out(skip_sel),
      .discharge_out(discharge), .current_limit_out(cur_lim),
      .test_mode_out(test_mode), .ref_code_out(ref_code),
      .target_code_out(target_code), .ref_settled_out(settled),
      .load_current_out(load_current), .core_rail_fault_out(core_fault),
      .regulator_fault_irq_out(fault_irq));

   // --------------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task cmp_val(input logic [9:0] got, input logic [9:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task step(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task set_mode(input logic [2:0] v);
      core_mode_field_in = v;
      step(4);
   endtask

   task key(input logic [7:0] a, input logic [7:0] b);
      test_key_in = a;
      test_key_wr_in = 1'b1;
      step(1);
      test_key_in = b;
      step(1);
      test_key_wr_in = 1'b0;
      step(2);
   endtask

   task cpu_load(input logic gfx, input logic [6:0] v);
      int k;
      load_gfx = gfx;
      load_code = v;
      load_req = 1'b1;
      step(1);
      load_req = 1'b0;
      k = 0;
      while (cpu_busy === 1'b1 && k < 100) begin
         step(1);
         k++;
      end
   endtask

   // timing window is loose at the start: the ramp began inside cpu_load
   task ramp_to(input logic [6:0] from, input logic [6:0] to);
      int exp, k;
      exp = (from > to ? from - to : to - from) * brmc_pkg::STEP_CYCLES;
      k = 0;
      while (!(ref_code === to && settled === 1'b1) && k < exp + 200) begin
         step(1);
         k++;
      end
      cmp_val(10'(ref_code), 10'(to));
      cmp_bit(settled, 1'b1);
      cmp_bit(k + 20 >= exp && k <= exp + 5, 1'b1);
   endtask

   task wrap_up();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // watchdog well above the longest ramp sequence
   initial begin
      #(60000 * 10);
      mismatches++;
      wrap_up();
   end

   // --------------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------------
   initial begin
      {rst_n_in, core_code_override_in, test_key_wr_in, over_current_in} = 0;
      {load_ok_in, adc_valid_in, fault_ack_in, load_req, load_gfx} = 0;
      core_mode_field_in = brmc_pkg::MODE_OFF;
      {core_code_field_in, load_code, test_key_in, adc_data_in} = 0;
      step(6);
      cmp_bit(switch_en, 1'b0);
      cmp_bit(discharge, 1'b1);
      cmp_val(10'(target_code), 10'h07F);
      cmp_val(10'(ref_code), 10'h000);
      cmp_bit(fault_irq, 1'b0);
      cmp_bit(test_mode, 1'b0);
      cmp_val(load_current, 10'h000);
      rst_n_in = 1'b1;
      step(1);
      load_ok_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         m = modes[i];
         set_mode(m);
         cmp_bit(switch_en, m != brmc_pkg::MODE_OFF);
         cmp_bit(discharge, m == brmc_pkg::MODE_OFF);
         if (m != brmc_pkg::MODE_OFF)
            cmp_bit(pfm_sel, m == brmc_pkg::MODE_PFM);
         if (m[1])
            cmp_bit(skip_sel, m == brmc_pkg::MODE_APS);
      end
      set_mode(brmc_pkg::MODE_APS);
      load_ok_in = 1'b0;
      step(4);
      cmp_bit(skip_sel, 1'b0);
      set_mode(3'(rnd() % 4));
      cmp_bit(switch_en, 1'b1);
      cmp_bit(pfm_sel, 1'b0);
      set_mode(brmc_pkg::MODE_PWM);
      load_ok_in = 1'b1;
      step(4);
      cmp_bit(skip_sel, 1'b0);
      // timed ramps need a ramp at rest: let the climb to the reset code
      // that started with the auto skip mode set after off finish first
      for (int k = 0; k < 7000 && settled !== 1'b1; k++)
         step(1);
      // core loads alternating corner codes and random codes, each followed by a timed ramp
      for (int i = 0; i < 4; i++) begin
         c = (i % 2) ? 7'(rnd() % 32) : codes[i];
         d = 10'(ref_code);
         cpu_load(1'b0, c);
         cmp_val(10'(target_code), 10'(c));
         if (c != d[6:0])
            cmp_bit(settled, 1'b0);
         ramp_to(d[6:0], c);
         cpu_load(1'b1, ~c);
         cmp_val(10'(target_code), 10'(c));
         cmp_val(10'(ref_code), 10'(c));
      end
      core_code_field_in = c ^ 7'(rnd() | 32'h1);
      core_code_override_in = 1'b1;
      step(3);
      cmp_val(10'(target_code), 10'(core_code_field_in));
      core_code_override_in = 1'b0;
      set_mode(brmc_pkg::MODE_OFF);
      ramp_to(ref_code, 7'h00);
      cmp_bit(discharge, 1'b1);
      // fault raise, early ack, clear
      set_mode(brmc_pkg::MODE_PWM);
      over_current_in = 1'b1;
      step(5);
      cmp_bit(cur_lim, 1'b1);
      cmp_bit(core_fault, 1'b1);
      cmp_bit(fault_irq, 1'b1);
      fault_ack_in = 1'b1;
      step(2);
      cmp_bit(fault_irq, 1'b1);
      fault_ack_in = 1'b0;
      over_current_in = 1'b0;
      step(5);
      cmp_bit(core_fault, 1'b0);
      cmp_bit(fault_irq, 1'b1);
      fault_ack_in = 1'b1;
      step(1);
      fault_ack_in = 1'b0;
      step(2);
      cmp_bit(fault_irq, 1'b0);
      // unlock keys: only the exact pair in order opens test mode
      key(brmc_pkg::KEY_A, brmc_pkg::KEY_B);
      cmp_bit(test_mode, 1'b1);
      key(brmc_pkg::KEY_B, brmc_pkg::KEY_A);
      cmp_bit(test_mode, 1'b0);
      key(brmc_pkg::KEY_A, 8'h3C);
      cmp_bit(test_mode, 1'b0);
      for (int i = 0; i < 6; i++) begin
         d = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'(rnd());
         adc_data_in = d;
         adc_valid_in = 1'b1;
         step(1);
         adc_valid_in = 1'b0;
         adc_data_in = ~d;
         step(2);
         cmp_val(load_current, d);
      end
      wrap_up();
   end
endmodule
